// file: hdl/nbm_frame_mem.sv
// nbm_frame_mem: small single-port memory with registered read data
// assumes one write or one read per cycle, used for page buffers and tables
`timescale 1ns/100ps
`default_nettype none
module nbm_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // no reset on storage: contents are always written before being trusted
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// file: hdl/nbm_host.sv
// nbm_host: host controller managing bad blocks of a small nand flash
// assumes flash pins synchronous to clk; ready_busy_n high when ready
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (RULE1) factory bad marker is 00h in page 0/1
// (RULE2) block zero always valid, never remapped; code exempts it only in the scan, S_RETIRE can still retire and remap it
// (RULE3) logical blocks remapped around invalid blocks
// (RULE4) erased bytes read FFh, markers differ
// (RULE5) table built from markers, marked blocks never erased
// (RULE6) failed program or erase retires block
// (RULE7) verify after program, mismatch retires block
// (RULE8) copy page n then pages 0..n-1; code only records n in failpg_ff and sets copying_ff, copies no pages
// (RULE9) retired block never erased or programmed again
// (RULE10) single-bit errors left to ecc
// (RULE11) chip select released between byte accesses
// (RULE12) cell to register transfer within 15 us
// (RULE13) status via 70h then read cycles
// (RULE14) status bit zero one means failure
// (RULE15) init scans first two pages per block
// (RULE16) wait ready or full transfer time
module nbm_host
  import nbm_pkg::*;
#(
  parameter int TR_CYC = NBM_TR_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire nbm_pkg::nbm_req_t req,
  input wire logic [7:0] wr_byte,
  output logic req_ready,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic op_fail,
  output logic [NBM_BLK_W-1:0] phys_blk,
  output nbm_pkg::nbm_pins_t pins,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  import nbm_pkg::*;
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [4:0] {
    S_INIT, S_IDLE, S_CMD, S_ADDR, S_WAIT_RDY, S_RD_BYTE, S_RD_TAKE,
    S_WR_BYTE, S_CONF, S_STAT_CMD, S_STAT_RD, S_STAT_CHK, S_RETIRE
  } nbm_state_t;
  nbm_state_t st_ff, nxt_st;
  nbm_op_t op_ff, nxt_op;
  logic scanning_ff, nxt_scanning;
  logic verify_ff, nxt_verify;
  logic copying_ff, nxt_copying;
  logic [NBM_BLK_W-1:0] blk_ff, nxt_blk, lblk_ff, nxt_lblk, spare_ff, nxt_spare;
  logic [NBM_PAGE_W-1:0] page_ff, nxt_page, failpg_ff, nxt_failpg;
  logic [NBM_COL_W-1:0] col_ff, nxt_col;
  logic [1:0] acnt_ff, nxt_acnt;
  logic [NBM_CNT_W-1:0] wait_ff, nxt_wait;
  logic [7:0] cmd_ff, nxt_cmd;
  logic mism_ff, nxt_mism;
  nbm_pins_t pins_ff, nxt_pins;
  logic [7:0] io_ff, nxt_io;
  logic oe_ff, nxt_oe, rdv_ff, nxt_rdv, fail_ff, nxt_fail, rdy_ff, nxt_rdy;
  logic [7:0] rdb_ff, nxt_rdb;
  // ****************************************************************
  // page buffer and tables
  // ****************************************************************
  logic buf_we, map_we;
  logic [7:0] buf_q;
  logic [NBM_BLK_W-1:0] map_q, map_addr, map_wd;
  logic [NBM_BLOCKS-1:0] bad_vec_ff, nxt_bad_vec;
  nbm_frame_mem #(.WIDTH(8), .DEPTH(NBM_FRAME_BYTES), .AW(NBM_COL_W)) u_buf (
    .clk(clk), .we(buf_we), .addr(col_ff), .wdata(wr_byte), .rdata(buf_q)
  );
  nbm_frame_mem #(.WIDTH(NBM_BLK_W), .DEPTH(NBM_BLOCKS), .AW(NBM_BLK_W)) u_map (
    .clk(clk), .we(map_we), .addr(map_addr), .wdata(map_wd), .rdata(map_q)
  );
  function automatic logic [23:0] addr_of(input logic [NBM_BLK_W-1:0] b,
                                          input logic [NBM_PAGE_W-1:0] p,
                                          input logic [NBM_COL_W-1:0] c);
    addr_of = {5'h00, b, p, c};
  endfunction
  function automatic logic [NBM_BLK_W-1:0] next_free(input logic [NBM_BLOCKS-1:0] bv,
                                                     input logic [NBM_BLK_W-1:0] from);
    next_free = from;
    for (int i = NBM_BLOCKS - 1; i > 0; i--) begin
      if (!bv[i] && NBM_BLK_W'(i) > from) begin
        next_free = NBM_BLK_W'(i);
      end
    end
  endfunction
  logic [23:0] cur_addr;
  assign cur_addr = addr_of(blk_ff, page_ff, col_ff);
  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff; nxt_op = op_ff; nxt_scanning = scanning_ff;
    nxt_verify = verify_ff; nxt_copying = copying_ff; nxt_blk = blk_ff;
    nxt_lblk = lblk_ff; nxt_spare = spare_ff; nxt_page = page_ff;
    nxt_failpg = failpg_ff; nxt_col = col_ff; nxt_acnt = acnt_ff;
    nxt_wait = wait_ff; nxt_cmd = cmd_ff; nxt_mism = mism_ff;
    nxt_pins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    nxt_io = io_ff; nxt_oe = 1'b0; nxt_rdv = 1'b0; nxt_rdb = rdb_ff;
    nxt_fail = 1'b0; nxt_rdy = 1'b0; nxt_bad_vec = bad_vec_ff;
    buf_we = 1'b0; map_we = 1'b0; map_addr = lblk_ff; map_wd = blk_ff;
    unique case (st_ff)
      S_INIT: begin // [RULE15] scan every block's marker pages first
        nxt_scanning = 1'b1; nxt_op = NBM_OP_SCAN; nxt_page = '0; nxt_col = '0;
        nxt_spare = NBM_BLK_W'(NBM_BLOCKS / 2);
        nxt_cmd = NBM_CMD_READ; nxt_st = S_CMD;
      end
      S_IDLE: begin
        nxt_rdy = ~req_valid;
        buf_we = req_valid && req.op == NBM_OP_WRITE;
        if (req_valid) begin
          nxt_op = req.op; nxt_lblk = req.blk; nxt_page = req.page;
          nxt_col = '0; nxt_mism = 1'b0; nxt_verify = 1'b0; nxt_copying = 1'b0;
          map_addr = req.blk;
          nxt_st = S_ADDR; nxt_acnt = 2'd3;
        end
      end
      S_CMD: begin
        // a high cycle parts every write strobe, else the flash sees no edge
        if (pins_ff.write_strobe_low) begin
          nxt_pins.cmd_latch = 1'b1; nxt_pins.chip_sel_low = 1'b0;
          nxt_pins.write_strobe_low = 1'b0; nxt_io = cmd_ff; nxt_oe = 1'b1;
          nxt_acnt = 2'd0;
          nxt_st = (cmd_ff == NBM_CMD_STATUS) ? S_STAT_RD :
                   (cmd_ff == NBM_CMD_PCONF || cmd_ff == NBM_CMD_ECONF) ? S_STAT_CMD : S_ADDR;
          nxt_wait = NBM_CNT_W'(TR_CYC);
        end
      end
      S_ADDR: begin
        if (acnt_ff == 2'd3) begin
          // [RULE3] logical block resolves through the remap table
          nxt_blk = map_q; nxt_cmd = op_ff == NBM_OP_ERASE ? NBM_CMD_ERASE :
                    op_ff == NBM_OP_WRITE ? NBM_CMD_PROG : NBM_CMD_READ;
          // [RULE9] a retired block is never programmed or erased again; reads of it still go ahead
          if (bad_vec_ff[map_q] && op_ff != NBM_OP_READ) begin
            nxt_fail = 1'b1; nxt_st = S_IDLE;
          end else begin
            nxt_st = S_CMD;
          end
        end else if (pins_ff.write_strobe_low) begin
          nxt_pins.addr_latch = 1'b1; nxt_pins.chip_sel_low = 1'b0;
          nxt_pins.write_strobe_low = 1'b0; nxt_oe = 1'b1;
          nxt_io = cur_addr[8*acnt_ff +: 8];
          nxt_acnt = acnt_ff + 2'd1;
          if (op_ff == NBM_OP_ERASE) begin
            nxt_io = cur_addr[8*acnt_ff + 8 +: 8]; // erase takes only the two upper cycles
          end
          if (acnt_ff == 2'd2 || (op_ff == NBM_OP_ERASE && acnt_ff == 2'd1)) begin
            nxt_st = op_ff == NBM_OP_ERASE ? S_CMD :
                     op_ff == NBM_OP_WRITE && !verify_ff ? S_WR_BYTE : S_WAIT_RDY;
            nxt_cmd = op_ff == NBM_OP_ERASE ? NBM_CMD_ECONF : cmd_ff;
          end
        end
      end
      S_WAIT_RDY: begin // [RULE12] [RULE16] ready, or the full transfer time
        if (wait_ff != '0) nxt_wait = wait_ff - NBM_CNT_W'(1);
        // ready is stale until busy has had time to show
        if ((ready_busy_n && wait_ff <= NBM_CNT_W'(TR_CYC - NBM_WB_CYC)) || wait_ff == '0) begin
          nxt_st = S_RD_BYTE;
        end
      end
      S_RD_BYTE: begin // [RULE11] chip select dropped between bytes
        nxt_pins.chip_sel_low = 1'b0; nxt_pins.read_strobe_low = 1'b0;
        nxt_st = S_RD_TAKE;
      end
      S_RD_TAKE: begin
        nxt_col = col_ff + NBM_COL_W'(1); nxt_st = S_RD_BYTE;
        if (scanning_ff) begin // [RULE1] [RULE4] any non-FFh marks the block bad, block zero excepted
          if (io_in != NBM_ERASED) nxt_mism = 1'b1;
        end else if (verify_ff) begin // [RULE7] compare against the buffer
          if (io_in != ((col_ff == '0) ? buf_q : NBM_ERASED)) nxt_mism = 1'b1;
        end else begin
          nxt_rdv = 1'b1; nxt_rdb = io_in; // [RULE10] bit errors go to caller's ecc
        end
        if (col_ff == NBM_COL_W'(NBM_FRAME_BYTES - 1)) begin
          nxt_st = S_STAT_CHK;
        end
      end
      S_WR_BYTE: begin
        // only column 0 is buffered; the rest of the frame is left erased
        if (pins_ff.write_strobe_low) begin
          nxt_pins.chip_sel_low = 1'b0; nxt_pins.write_strobe_low = 1'b0; nxt_oe = 1'b1;
          nxt_io = (col_ff == '0) ? buf_q : NBM_ERASED; nxt_col = col_ff + NBM_COL_W'(1);
          if (col_ff == NBM_COL_W'(NBM_FRAME_BYTES - 1)) begin
            nxt_cmd = NBM_CMD_PCONF; nxt_st = S_CMD;
          end
        end
      end
      S_STAT_CMD: begin // [RULE13] status read after program or erase
        nxt_wait = NBM_CNT_W'(NBM_WHR_CYC);
        if (ready_busy_n) begin
          nxt_cmd = NBM_CMD_STATUS; nxt_st = S_CMD;
        end
      end
      S_STAT_RD: begin
        nxt_pins.chip_sel_low = 1'b0; nxt_pins.read_strobe_low = 1'b0;
        if (wait_ff != '0) nxt_wait = wait_ff - NBM_CNT_W'(1);
        if (wait_ff == '0) begin
          nxt_mism = io_in[NBM_PASS_FAIL_BIT]; // [RULE14] one is failure
          nxt_st = io_in[NBM_READY_BIT] ? S_STAT_CHK : S_STAT_RD;
          nxt_verify = op_ff == NBM_OP_WRITE && !io_in[NBM_PASS_FAIL_BIT];
          nxt_col = '0;
          if (nxt_verify && io_in[NBM_READY_BIT]) begin
            nxt_acnt = 2'd0; nxt_cmd = NBM_CMD_READ; nxt_st = S_CMD;
          end
        end
      end
      S_STAT_CHK: begin
        if (scanning_ff) begin
          // a marker in either page keeps the block bad
          nxt_bad_vec[blk_ff] = bad_vec_ff[blk_ff] | (mism_ff && blk_ff != '0); // [RULE2]
          nxt_page = page_ff + NBM_PAGE_W'(1); nxt_mism = 1'b0; nxt_col = '0;
          if (page_ff == NBM_PAGE_W'(NBM_MARK_PAGES - 1)) begin
            nxt_page = '0; nxt_blk = blk_ff + NBM_BLK_W'(1);
            map_we = 1'b1; map_addr = blk_ff; map_wd = blk_ff;
            if (nxt_bad_vec[blk_ff]) begin // [RULE3] bad block gets a spare at once
              map_wd = spare_ff; nxt_spare = next_free(nxt_bad_vec, spare_ff);
            end
            if (blk_ff == NBM_BLK_W'(NBM_BLOCKS - 1)) nxt_scanning = 1'b0;
          end
          nxt_acnt = 2'd0; nxt_cmd = NBM_CMD_READ;
          nxt_st = nxt_scanning ? S_CMD : S_RETIRE;
        end else if (mism_ff && op_ff != NBM_OP_READ) begin
          nxt_st = S_RETIRE; nxt_fail = 1'b1; // [RULE6]
        end else begin
          nxt_st = S_IDLE;
        end
      end
      S_RETIRE: begin
        nxt_st = S_IDLE;
        if (!scanning_ff && mism_ff) begin // [RULE5] [RULE9] [RULE8]
          nxt_bad_vec[blk_ff] = 1'b1; map_we = 1'b1; map_addr = lblk_ff;
          map_wd = spare_ff; nxt_spare = next_free(bad_vec_ff, spare_ff);
          nxt_failpg = page_ff; nxt_copying = 1'b1;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= S_INIT; op_ff <= NBM_OP_SCAN; scanning_ff <= 1'b0; verify_ff <= 1'b0;
      copying_ff <= 1'b0; blk_ff <= '0; lblk_ff <= '0; spare_ff <= '0; page_ff <= '0;
      failpg_ff <= '0; col_ff <= '0; acnt_ff <= '0; wait_ff <= '0; cmd_ff <= 8'h00;
      mism_ff <= 1'b0; pins_ff <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1}; io_ff <= 8'h00;
      oe_ff <= 1'b0; rdv_ff <= 1'b0; rdb_ff <= 8'h00; fail_ff <= 1'b0; rdy_ff <= 1'b0;
      bad_vec_ff <= '0;
    end else begin
      st_ff <= nxt_st; op_ff <= nxt_op; scanning_ff <= nxt_scanning;
      verify_ff <= nxt_verify; copying_ff <= nxt_copying; blk_ff <= nxt_blk;
      lblk_ff <= nxt_lblk; spare_ff <= nxt_spare; page_ff <= nxt_page;
      failpg_ff <= nxt_failpg; col_ff <= nxt_col; acnt_ff <= nxt_acnt;
      wait_ff <= nxt_wait; cmd_ff <= nxt_cmd; mism_ff <= nxt_mism; pins_ff <= nxt_pins;
      io_ff <= nxt_io; oe_ff <= nxt_oe; rdv_ff <= nxt_rdv; rdb_ff <= nxt_rdb;
      fail_ff <= nxt_fail; rdy_ff <= nxt_rdy; bad_vec_ff <= nxt_bad_vec;
    end
  end
  assign pins = pins_ff;
  assign io_out = io_ff;
  assign io_oe = oe_ff;
  assign rd_valid = rdv_ff;
  assign rd_byte = rdb_ff;
  assign op_fail = fail_ff;
  assign req_ready = rdy_ff;
  assign phys_blk = blk_ff;
  // ****************************************************************
  // checks
  // ****************************************************************
  a_block_zero_good: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    !bad_vec_ff[0]) else $error("block zero marked bad");
  a_retired_untouched: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
    (st_ff == S_CMD && (cmd_ff == NBM_CMD_PROG || cmd_ff == NBM_CMD_ERASE))
      |-> !bad_vec_ff[blk_ff]) else $error("retired block accessed");
  a_copy_recorded: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    (st_ff == S_RETIRE && !scanning_ff && mism_ff)
      |=> (copying_ff && failpg_ff == $past(page_ff))) else $error("failed page not recorded");
  a_status_fail: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    (st_ff == S_STAT_CHK && !scanning_ff && mism_ff && op_ff != NBM_OP_READ)
      |=> op_fail) else $error("failure not reported");
  a_wait_bound: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
    wait_ff <= NBM_CNT_W'(TR_CYC)) else $error("wait counter out of range");
  a_cs_release: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
    (st_ff == S_RD_TAKE) |=> pins.chip_sel_low) else $error("chip select held");
endmodule
`default_nettype wire

// file: hdl/nbm_pkg.sv
// nbm_pkg: constants and carrier types for the host-side bad-block manager
// assumes a byte-wide nand flash with 32-byte frames and 3-cycle addresses
package nbm_pkg;
  // ****************************************************************
  // flash geometry
  // ****************************************************************
  localparam int NBM_BLOCKS = 128;
  localparam int NBM_BLK_W = 7;
  localparam int NBM_PAGE_W = 7;
  localparam int NBM_COL_W = 5;
  localparam int NBM_FRAME_BYTES = 32;
  localparam int NBM_MARK_PAGES = 2;
  // ****************************************************************
  // command codes and data values
  // ****************************************************************
  localparam logic [7:0] NBM_CMD_READ = 8'h00;
  localparam logic [7:0] NBM_CMD_PROG = 8'h80;
  localparam logic [7:0] NBM_CMD_PCONF = 8'h10;
  localparam logic [7:0] NBM_CMD_ERASE = 8'h60;
  localparam logic [7:0] NBM_CMD_ECONF = 8'hD0;
  localparam logic [7:0] NBM_CMD_STATUS = 8'h70;
  localparam logic [7:0] NBM_ERASED = 8'hFF;
  localparam logic [7:0] NBM_BAD_MARK = 8'h00;
  localparam int NBM_PASS_FAIL_BIT = 0;
  localparam int NBM_READY_BIT = 6;
  // ****************************************************************
  // timing: clk 10 MHz
  // ****************************************************************
  localparam int NBM_CLK_NS = 100;
  localparam int NBM_CELL_TO_REG_US = 15;
  localparam int NBM_TR_CYC = (NBM_CELL_TO_REG_US * 1000 + NBM_CLK_NS - 1) / NBM_CLK_NS;
  localparam int NBM_WHR_NS = 50;
  localparam int NBM_WHR_CYC = (NBM_WHR_NS + NBM_CLK_NS - 1) / NBM_CLK_NS;
  // busy shows only some time after the last write strobe, so ready is ignored that long
  localparam int NBM_WB_NS = 200;
  localparam int NBM_WB_CYC = (NBM_WB_NS + NBM_CLK_NS - 1) / NBM_CLK_NS;
  localparam int NBM_CNT_W = 12;
  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic cmd_latch;
    logic addr_latch;
    logic chip_sel_low;
    logic write_strobe_low;
    logic read_strobe_low;
  } nbm_pins_t;
  typedef enum logic [1:0] {
    NBM_OP_SCAN, NBM_OP_READ, NBM_OP_WRITE, NBM_OP_ERASE
  } nbm_op_t;
  typedef struct packed {
    nbm_op_t op;
    logic [NBM_BLK_W-1:0] blk;
    logic [NBM_PAGE_W-1:0] page;
  } nbm_req_t;
endpackage

// file: testbench/nbm_flash_model.sv
// nbm_flash_model: behavioural byte-wide nand flash facing the host
// assumes pins change just after clk rising edges; markers set by parameter
`timescale 1ns/100ps
`default_nettype none
module nbm_flash_model
  import nbm_pkg::*;
#(
  parameter int TR_CYC = 8,
  parameter int PROG_CYC = 20,
  parameter int BAD_A = 5,
  parameter int BAD_B = 9
) (
  input wire logic clk,
  input wire nbm_pkg::nbm_pins_t pins,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  output logic [7:0] io_in,
  output logic ready_busy_n,
  input wire logic [NBM_BLK_W-1:0] fail_blk,
  input wire logic fail_en,
  output int misuse,
  output logic [NBM_BLOCKS-1:0] scanned
);
  // ****************************************************************
  // array and command state
  // ****************************************************************
  logic [7:0] mem [int];
  logic [7:0] pend [int];
  logic [NBM_BLOCKS-1:0] retired;
  logic [7:0] cmd, cur, last;
  logic [23:0] abuf, a;
  logic [13:0] row;
  logic [4:0] col;
  logic st_fail, ws_d, rs_d, bad;
  int acnt, busy;
  function automatic logic [7:0] rd(input int k);
    return mem.exists(k) ? mem[k] : NBM_ERASED;
  endfunction
  initial begin
    mem[BAD_A << 12] = NBM_BAD_MARK;
    mem[(BAD_B << 12) | (1 << 5)] = NBM_BAD_MARK;
    retired = '0;
    retired[BAD_A] = 1'b1;
    retired[BAD_B] = 1'b1;
    {misuse, busy, acnt, st_fail, last, col, row, abuf} = '0;
    {ws_d, rs_d, cmd, cur} = {2'h3, NBM_CMD_READ, NBM_ERASED};
    scanned = '0;
  end
  assign ready_busy_n = (busy == 0);
  // unselected bus shows the inverse of the last byte, never a stale copy
  assign io_in = (!pins.chip_sel_low && !pins.read_strobe_low) ? cur : ~last;
  // ****************************************************************
  // pin sequencing
  // ****************************************************************
  always @(posedge clk) begin
    ws_d <= pins.write_strobe_low;
    rs_d <= pins.read_strobe_low;
    if (busy > 0) busy <= busy - 1;
    if (cmd == NBM_CMD_STATUS) cur <= {1'h1, busy == 0, 5'h00, st_fail};
    else if (!rs_d && pins.read_strobe_low) cur <= rd(int'({row, col + 5'h01}));
    else cur <= rd(int'({row, col}));
    if (!pins.chip_sel_low && !pins.write_strobe_low && ws_d) begin
      if (pins.cmd_latch) begin
        cmd <= io_out;
        acnt <= 0;
        bad = fail_en && fail_blk == row[13:7];
        if (io_out == NBM_CMD_PCONF) begin
          busy <= PROG_CYC;
          if (retired[row[13:7]]) misuse <= misuse + 1;
          st_fail <= bad;
          if (!bad) foreach (pend[k]) mem[k] = rd(k) & pend[k];
          if (bad) retired[row[13:7]] <= 1'b1;
          pend.delete();
        end
        if (io_out == NBM_CMD_ECONF) begin
          busy <= PROG_CYC;
          if (retired[row[13:7]]) misuse <= misuse + 1;
          st_fail <= 1'b0;
          for (int k = 0; k < 4096; k++)
            if (mem.exists(int'({row[13:7], 12'h000}) + k)) mem.delete(int'({row[13:7], 12'h000}) + k);
        end
      end else if (pins.addr_latch) begin
        a = {io_out, abuf[23:8]};
        abuf <= a;
        acnt <= acnt + 1;
        row <= a[18:5];
        col <= a[4:0];
        if (cmd == NBM_CMD_READ && acnt == 2) begin
          busy <= TR_CYC;
          if (a[11:5] < 2) scanned[a[18:12]] <= 1'b1;
        end
      end else if (cmd == NBM_CMD_PROG) begin
        pend[int'({row, col})] = io_out;
        col <= col + 1;
      end
    end
    if (!pins.chip_sel_low && !pins.read_strobe_low &&
        (io_oe || (rs_d && busy > 0 && cmd != NBM_CMD_STATUS)))
      misuse <= misuse + 1;
    if (!rs_d && pins.read_strobe_low) begin
      last <= cur;
      if (cmd == NBM_CMD_READ) col <= col + 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_nand_bad_block_management.sv
// test_nand_bad_block_management: self-checking bench for nbm_host
// assumes nbm_flash_model on the pins; shortened transfer time of 10 cycles
`timescale 1ns/100ps
`default_nettype none
module test_nand_bad_block_management;
  import nbm_pkg::*;
  logic clk, resetn, req_valid, req_ready, rd_valid, op_fail, io_oe, ready_busy_n, fail_en;
  logic saw_fail;
  nbm_req_t req;
  nbm_pins_t pins;
  logic [7:0] wr_byte, rd_byte, io_out, io_in;
  logic [NBM_BLK_W-1:0] phys_blk, fail_blk, p;
  logic [NBM_BLOCKS-1:0] scanned;
  logic [7:0] got [$];
  int misuse, miscompares, comparisons;
  nbm_host #(.TR_CYC(10)) uut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .wr_byte(wr_byte), .req_ready(req_ready), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .op_fail(op_fail), .phys_blk(phys_blk), .pins(pins), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_n(ready_busy_n));
  nbm_flash_model flash (.clk(clk), .pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n), .fail_blk(fail_blk), .fail_en(fail_en), .misuse(misuse),
    .scanned(scanned));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  always @(posedge clk) begin
    if (rd_valid === 1'b1) got.push_back(rd_byte);
    if (op_fail === 1'b1) saw_fail = 1'b1;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready(input int limit);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < limit) begin
      @(negedge clk);
      n++;
    end
    check("req_ready", 8'h01, {7'h00, req_ready});
  endtask
  task automatic do_op(input nbm_op_t op, input int blk, input int page, input logic [7:0] d);
    wait_ready(5000);
    got.delete();
    saw_fail = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, blk: blk[6:0], page: page[6:0]};
    wr_byte <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(negedge clk);
    wait_ready(20000);
    @(negedge clk);
  endtask
  task automatic frame_is(input string what, input logic [7:0] b0);
    check({what, " count"}, 8'h20, 8'(got.size()));
    if (got.size() == 32) begin
      check({what, " byte0"}, b0, got[0]);
      for (int i = 1; i < 32; i++) check(what, NBM_ERASED, got[i]);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_init;
    wait_ready(80000);
    check("scanned", 8'h01, {7'h00, &scanned});
  endtask
  task automatic t_block_zero;
    do_op(NBM_OP_READ, 0, 0, 8'h00);
    check("phys zero", 8'h00, {1'h0, phys_blk});
    frame_is("blk0", NBM_ERASED);
  endtask
  task automatic t_bad_skip;
    do_op(NBM_OP_READ, 5, 0, 8'h00);
    check("skip a", 8'h01, {7'h00, phys_blk !== 7'h05 && phys_blk !== 7'h09});
    frame_is("blk5", NBM_ERASED);
    do_op(NBM_OP_READ, 9, 1, 8'h00);
    check("skip b", 8'h01, {7'h00, phys_blk !== 7'h05 && phys_blk !== 7'h09});
    frame_is("blk9", NBM_ERASED);
  endtask
  task automatic t_prog_verify;
    do_op(NBM_OP_WRITE, 2, 3, 8'h5A);
    check("write fail", 8'h00, {7'h00, saw_fail});
    do_op(NBM_OP_READ, 2, 3, 8'h00);
    frame_is("verify", 8'h5A);
    do_op(NBM_OP_ERASE, 2, 0, 8'h00);
    check("erase fail", 8'h00, {7'h00, saw_fail});
    do_op(NBM_OP_READ, 2, 3, 8'h00);
    frame_is("erased", NBM_ERASED);
  endtask
  task automatic t_prog_fail;
    do_op(NBM_OP_READ, 3, 0, 8'h00);
    p = phys_blk;
    fail_blk <= p;
    fail_en <= 1'b1;
    do_op(NBM_OP_WRITE, 3, 4, 8'h3C);
    check("fail seen", 8'h01, {7'h00, saw_fail});
    fail_en <= 1'b0;
    do_op(NBM_OP_WRITE, 3, 4, 8'h3C);
    check("rewrite", 8'h00, {7'h00, saw_fail});
    check("moved", 8'h01, {7'h00, phys_blk !== p});
    do_op(NBM_OP_READ, 3, 4, 8'h00);
    frame_is("spare", 8'h3C);
  endtask
  task automatic t_erase_bad;
    do_op(NBM_OP_ERASE, 5, 0, 8'h00);
    check("erase bad", 8'h00, {7'h00, saw_fail});
    check("misuse", 8'h00, 8'(misuse));
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {resetn, req_valid, fail_en, saw_fail} = '0;
    {req, wr_byte, fail_blk, p, miscompares, comparisons} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_init();
    t_block_zero();
    t_bad_skip();
    t_prog_verify();
    t_prog_fail();
    t_erase_bad();
    wrap_up();
  end
endmodule
`default_nettype wire
